// ==== hdl/sep_pkg.sv ====
package sep_pkg;

   // Serial framing
   localparam int          BYTE_BITS      = 8;
   localparam int          ADDR_BITS      = 13;
   localparam int          PAGE_BITS      = 5;
   localparam int          PAGE_BYTES     = 32;
   localparam int          ARRAY_BYTES    = 8192;
   localparam logic [2:0]  LAST_BIT       = 3'h7;
   localparam logic [2:0]  FIRST_BIT      = 3'h0;

   // Opcode layout: upper nibble zero, bit 3 ignored, low three bits select
   localparam logic [3:0]  OPC_HI         = 4'h0;
   localparam logic [2:0]  OPC_SET_WL     = 3'h6;
   localparam logic [2:0]  OPC_CLR_WL     = 3'h4;
   localparam logic [2:0]  OPC_SRD        = 3'h5;
   localparam logic [2:0]  OPC_SWR        = 3'h1;
   localparam logic [2:0]  OPC_ARD        = 3'h3;
   localparam logic [2:0]  OPC_AWR        = 3'h2;

   // Status register fields
   localparam int          ST_BUSY        = 0;
   localparam int          ST_WEL         = 1;
   localparam int          ST_BG_LO       = 2;
   localparam int          ST_BG_HI       = 3;
   localparam int          ST_ARM         = 7;
   localparam logic [7:0]  ST_BUSY_VALUE  = 8'hff;
   localparam logic [1:0]  BG_RESET       = 2'h0;

   // Block guard levels and lower bounds of the guarded ranges
   localparam logic [1:0]  BG_NONE        = 2'h0;
   localparam logic [1:0]  BG_QUARTER     = 2'h1;
   localparam logic [1:0]  BG_HALF        = 2'h2;
   localparam logic [12:0] BG_QUARTER_LO  = 13'h1800;
   localparam logic [12:0] BG_HALF_LO     = 13'h1000;

   // Self-timed write
   localparam int          CLK_PERIOD_NS  = 8;
   localparam int          T_WRITE_NS     = 5000000;
   localparam int          WRITE_CYCLES   = T_WRITE_NS / CLK_PERIOD_NS;
   localparam int          BUSY_W         = 20;

   // Read prefetch buffer
   localparam int          RD_FIFO_DEPTH  = 4;

   typedef enum logic [2:0] {
      no_cmd,
      set_write_latch_cmd,
      clear_write_latch_cmd,
      status_read_cmd,
      status_write_cmd,
      array_read_cmd,
      array_write_cmd
   } sep_cmd_e;

   typedef enum logic [1:0] {
      PH_OPCODE,
      PH_ADDR,
      PH_DATA,
      PH_IGNORE
   } sep_phase_e;

endpackage : sep_pkg

// ==== hdl/sep_eeprom.sv ====
`timescale 1ns/1ps

module sep_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_flush,
   // Fill side
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   // Drain side
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0]  wr_ptr_ff;
   logic [AW:0]  rd_ptr_ff;
   logic         push;
   logic         pop;

   assign o_valid = (wr_ptr_ff != rd_ptr_ff);
   assign o_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                      (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
   assign push    = i_valid && o_ready && !i_flush;
   assign pop     = o_valid && i_ready && !i_flush;
   assign o_data  = mem[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_ff[AW-1:0]] <= i_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else if (i_flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
      end
   end

endmodule : sep_fifo

// Function
// R1: Hardware protection is active only with protect pin low and arm bit set.
// R2: Pause input low freezes the serial sequence; release resumes it unchanged.
// R3: Master changes pause only while clock low; tied high disables pausing.
// R4: Status register is 8 bits; writable only with latch set, no hardware protection.
// R5: Status bit 0 reads 1 while an internal write is busy.
// R6: While busy only the status read instruction is acted on.
// R7: Status bit 1 is the write latch; clear latch forbids any modification.
// R8: Write latch is 0 after reset; only set-write-latch sets it.
// R9: Status bits 2 and 3 are block guard bits, reset to 0.
// R10: Guard bits select none, top quarter, top half or whole array.
// R11: Status bits 4 to 6 are never stored and read 0 when idle.
// R12: Arm bit cannot go from 1 to 0 while protect pin is low.
// R13: Hardware protection guards only the status register, never the array.
// R14: During an internal write a status read returns all ones.
// R15: Instructions start with select low; opcode bits sampled on clock rise.
// R16: Output bits change on the falling serial clock edge.
// R17: Opcode, address and data travel most significant bit first.
// R18: Select rising ends the transaction and launches the operation.
// R19: Opcodes x6 and x4 set and clear the write latch, no operands.
// R20: Opcode x5 reads status, opcode x1 writes status with one data byte.
// R21: Opcodes x3 and x2 read and write the array after 16 address bits.
// R22: Write latch clears after clear-latch, status write or array write completes.
// R23: Array write stays within one 32-byte page, wrapping; last 32 kept.
// R24: Array read streams sequential bytes, wrapping at the end, until select rises.
// R25: Only the lower 13 address bits select a byte.
// R26: Unknown opcodes and their following bytes are ignored.
// R27: Busy holds for a set number of cycles after select rises.
module sep_eeprom
   import sep_pkg::*;
#(
   parameter int P_WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Serial link pins
   input  wire logic i_cs_n,
   input  wire logic i_sck,
   input  wire logic i_si,
   output logic      o_so,
   output logic      o_so_oe,
   // Control pins
   input  wire logic i_wp_n,
   input  wire logic i_hold_n
);
   import sep_pkg::*;

   function automatic sep_cmd_e decode_op(input logic [7:0] op);
      sep_cmd_e c;
      c = no_cmd;
      if (op[7:4] == OPC_HI) begin
         case (op[2:0])
            OPC_SET_WL: c = set_write_latch_cmd;
            OPC_CLR_WL: c = clear_write_latch_cmd;
            OPC_SRD:    c = status_read_cmd;
            OPC_SWR:    c = status_write_cmd;
            OPC_ARD:    c = array_read_cmd;
            OPC_AWR:    c = array_write_cmd;
            default:    c = no_cmd;
         endcase
      end
      return c;
   endfunction : decode_op

   function automatic logic guarded(input logic [12:0] a, input logic [1:0] bg);
      logic g;
      g = 1'b1;
      if (bg == BG_NONE) begin
         g = 1'b0;
      end else if (bg == BG_QUARTER) begin
         g = (a >= BG_QUARTER_LO);
      end else if (bg == BG_HALF) begin
         g = (a >= BG_HALF_LO);
      end
      return g;
   endfunction : guarded

   // Pin synchronisers
   logic       cs_s1_ff, cs_s2_ff;
   logic       sck_s1_ff, sck_s2_ff, sck_d_ff;
   logic       si_s1_ff, si_s2_ff;
   logic       wp_s1_ff, wp_s2_ff;
   logic       hold_s1_ff, hold_s2_ff;
   logic       cs_d_ff;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_s1_ff   <= 1'b1;
         cs_s2_ff   <= 1'b1;
         cs_d_ff    <= 1'b1;
         sck_s1_ff  <= 1'b0;
         sck_s2_ff  <= 1'b0;
         sck_d_ff   <= 1'b0;
         si_s1_ff   <= 1'b0;
         si_s2_ff   <= 1'b0;
         wp_s1_ff   <= 1'b1;
         wp_s2_ff   <= 1'b1;
         hold_s1_ff <= 1'b1;
         hold_s2_ff <= 1'b1;
      end else begin
         cs_s1_ff   <= i_cs_n;
         cs_s2_ff   <= cs_s1_ff;
         cs_d_ff    <= cs_s2_ff;
         sck_s1_ff  <= i_sck;
         sck_s2_ff  <= sck_s1_ff;
         sck_d_ff   <= sck_s2_ff;
         si_s1_ff   <= i_si;
         si_s2_ff   <= si_s1_ff;
         wp_s1_ff   <= i_wp_n;
         wp_s2_ff   <= wp_s1_ff;
         hold_s1_ff <= i_hold_n;
         hold_s2_ff <= hold_s1_ff;
      end
   end

   // Transaction state
   sep_phase_e    phase_ff;
   sep_cmd_e      cmd_ff;
   logic [2:0]    bit_ff;
   logic [6:0]    in_sr_ff;
   logic          addr_byte_ff;
   logic [15:0]   addr_ff;
   logic [7:0]    sw_data_ff;
   logic          sw_have_ff;
   logic          wel_ff;
   logic [1:0]    bg_ff;
   logic          arm_ff;
   logic [BUSY_W-1:0] busy_cnt_ff;
   logic          wr_status_ff;
   logic [5:0]    commit_ff;
   logic [7:0]    pg_data [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pg_valid_ff;
   logic [PAGE_BITS-1:0]  col_ff;
   logic [7:0]    mem [ARRAY_BYTES];
   logic [ADDR_BITS-1:0]  rd_ptr_ff;
   logic          rd_run_ff;
   logic [6:0]    out_sr_ff;

   logic          cs_act;
   logic          cs_rise;
   logic          sck_rise;
   logic          sck_fall;
   logic          byte_done;
   logic [7:0]    rx_byte;
   logic          busy;
   logic          hw_prot;
   logic [7:0]    status;
   logic          addr_done;
   logic          start_wr;
   logic          out_phase;
   logic          load_out;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic [7:0]    fifo_out_data;
   logic          fifo_pop;
   logic          fifo_flush;

   assign cs_act    = !cs_s2_ff;                                         // [R15]
   assign cs_rise   = cs_s2_ff && !cs_d_ff;                              // [R18]
   // Pause masks both edges; steady pause at edges lets plain gating suffice
   assign sck_rise  = cs_act && hold_s2_ff && sck_s2_ff && !sck_d_ff;    // [R2] [R3]
   assign sck_fall  = cs_act && hold_s2_ff && !sck_s2_ff && sck_d_ff;    // [R2]
   assign rx_byte   = {in_sr_ff, si_s2_ff};                              // [R17]
   assign byte_done = sck_rise && (bit_ff == LAST_BIT);
   assign busy      = (busy_cnt_ff != '0);
   assign hw_prot   = !wp_s2_ff && arm_ff;                               // [R1]
   assign addr_done = byte_done && (phase_ff == PH_ADDR) && addr_byte_ff;

   // Busy overrides every field, unused bits otherwise read 0
   always_comb begin
      status           = '0;                                             // [R11]
      status[ST_BUSY]  = busy;                                           // [R5]
      status[ST_WEL]   = wel_ff;                                         // [R7]
      status[ST_BG_LO] = bg_ff[0];                                       // [R9]
      status[ST_BG_HI] = bg_ff[1];
      status[ST_ARM]   = arm_ff;
      if (busy) begin
         status = ST_BUSY_VALUE;                                         // [R14]
      end
   end

   // Opcode, address and operand capture on the rising clock edge
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_ff     <= PH_OPCODE;
         cmd_ff       <= no_cmd;
         bit_ff       <= FIRST_BIT;
         in_sr_ff     <= '0;
         addr_byte_ff <= 1'b0;
         addr_ff      <= '0;
         sw_data_ff   <= '0;
         sw_have_ff   <= 1'b0;
      end else if (!cs_act) begin
         phase_ff     <= PH_OPCODE;
         cmd_ff       <= no_cmd;
         bit_ff       <= FIRST_BIT;
         addr_byte_ff <= 1'b0;
         sw_have_ff   <= 1'b0;
      end else if (sck_rise) begin                                       // [R15]
         bit_ff   <= bit_ff + 1'b1;
         in_sr_ff <= rx_byte[6:0];
         if (byte_done) begin
            case (phase_ff)
               PH_OPCODE: begin
                  // Busy leaves only the status read alive
                  if (busy && decode_op(rx_byte) != status_read_cmd) begin  // [R6]
                     cmd_ff   <= no_cmd;
                     phase_ff <= PH_IGNORE;
                  end else begin
                     cmd_ff <= decode_op(rx_byte);                       // [R19] [R20] [R21]
                     case (decode_op(rx_byte))
                        array_read_cmd, array_write_cmd: begin
                           phase_ff <= PH_ADDR;                          // [R21]
                        end
                        status_read_cmd, status_write_cmd: begin
                           phase_ff <= PH_DATA;                          // [R20]
                        end
                        default: begin
                           phase_ff <= PH_IGNORE;                        // [R26]
                        end
                     endcase
                  end
               end
               PH_ADDR: begin
                  addr_ff      <= {addr_ff[7:0], rx_byte};               // [R17]
                  addr_byte_ff <= !addr_byte_ff;
                  if (addr_byte_ff) begin
                     phase_ff <= PH_DATA;
                  end
               end
               PH_DATA: begin
                  if (cmd_ff == status_write_cmd && !sw_have_ff) begin
                     sw_data_ff <= rx_byte;                              // [R20]
                     sw_have_ff <= 1'b1;
                  end
               end
               default: begin
                  phase_ff <= PH_IGNORE;                                 // [R26]
               end
            endcase
         end
      end
   end

   // Page buffer: column wraps inside the page, later bytes overwrite
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pg_valid_ff <= '0;
         col_ff      <= '0;
      end else if (byte_done && phase_ff == PH_OPCODE &&
                   !busy && decode_op(rx_byte) == array_write_cmd) begin
         pg_valid_ff <= '0;
      end else if (addr_done) begin
         col_ff <= rx_byte[PAGE_BITS-1:0];
      end else if (byte_done && phase_ff == PH_DATA && cmd_ff == array_write_cmd) begin
         pg_valid_ff[col_ff] <= 1'b1;
         col_ff              <= col_ff + 1'b1;                           // [R23]
      end
   end

   always_ff @(posedge i_clk) begin
      if (byte_done && phase_ff == PH_DATA && cmd_ff == array_write_cmd) begin
         pg_data[col_ff] <= rx_byte;                                     // [R23]
      end
   end

   // Launch a self-timed write on select rising
   always_comb begin
      start_wr = 1'b0;
      if (cs_rise && wel_ff) begin                                       // [R7] [R18]
         if (cmd_ff == array_write_cmd) begin
            start_wr = (pg_valid_ff != '0);                              // [R13]
         end else if (cmd_ff == status_write_cmd) begin
            start_wr = sw_have_ff && !hw_prot;                           // [R4] [R1]
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         busy_cnt_ff  <= '0;
         wr_status_ff <= 1'b0;
         commit_ff    <= '0;
      end else if (start_wr) begin
         busy_cnt_ff  <= BUSY_W'(P_WRITE_CYCLES);                        // [R27]
         wr_status_ff <= (cmd_ff == status_write_cmd);
         commit_ff    <= '0;
      end else if (busy) begin
         busy_cnt_ff <= busy_cnt_ff - 1'b1;
         if (commit_ff != 6'(PAGE_BYTES)) begin
            commit_ff <= commit_ff + 1'b1;
         end
      end
   end

   // Array commit, one page byte per cycle early in the busy window
   always_ff @(posedge i_clk) begin
      if (busy && !wr_status_ff && commit_ff != 6'(PAGE_BYTES) &&
          pg_valid_ff[commit_ff[PAGE_BITS-1:0]] &&
          !guarded({addr_ff[ADDR_BITS-1:PAGE_BITS], commit_ff[PAGE_BITS-1:0]}, bg_ff)) begin
         mem[{addr_ff[ADDR_BITS-1:PAGE_BITS], commit_ff[PAGE_BITS-1:0]}] <=  // [R10] [R25]
            pg_data[commit_ff[PAGE_BITS-1:0]];
      end
   end

   // Write latch and stored status fields
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wel_ff <= 1'b0;                                                 // [R8]
         bg_ff  <= BG_RESET;                                             // [R9]
         arm_ff <= 1'b0;
      end else if (busy_cnt_ff == BUSY_W'(1)) begin
         wel_ff <= 1'b0;                                                 // [R22]
         if (wr_status_ff) begin
            bg_ff  <= sw_data_ff[ST_BG_HI:ST_BG_LO];                     // [R4]
            // Hardware protection already blocks a 1 to 0 change at launch
            arm_ff <= sw_data_ff[ST_ARM];                                // [R12]
         end
      end else if (cs_rise && cmd_ff == set_write_latch_cmd) begin
         wel_ff <= 1'b1;                                                 // [R8]
      end else if (cs_rise && cmd_ff == clear_write_latch_cmd) begin
         wel_ff <= 1'b0;                                                 // [R22]
      end
   end

   // Read prefetch: stalls when the buffer fills, restarts per transaction
   assign fifo_flush = !cs_act || addr_done;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_ptr_ff <= '0;
         rd_run_ff <= 1'b0;
      end else if (!cs_act) begin
         rd_run_ff <= 1'b0;
      end else if (addr_done && cmd_ff == array_read_cmd) begin
         rd_ptr_ff <= {addr_ff[ADDR_BITS-BYTE_BITS-1:0], rx_byte};       // [R25]
         rd_run_ff <= 1'b1;
      end else if (rd_run_ff && fifo_in_ready) begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1;                                  // [R24]
      end
   end

   sep_fifo #(
      .W (BYTE_BITS),
      .D (RD_FIFO_DEPTH)
   ) sep_fifo_inst (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_flush (fifo_flush),
      .i_valid (rd_run_ff),
      .o_ready (fifo_in_ready),
      .i_data  (mem[rd_ptr_ff]),
      .o_valid (fifo_out_valid),
      .i_ready (fifo_pop),
      .o_data  (fifo_out_data)
   );

   // Output shifter on the falling clock edge
   assign out_phase = (phase_ff == PH_DATA) &&
                      (cmd_ff == status_read_cmd || cmd_ff == array_read_cmd);
   assign load_out  = sck_fall && out_phase && (bit_ff == FIRST_BIT);
   assign fifo_pop  = load_out && cmd_ff == array_read_cmd;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_so      <= 1'b0;
         out_sr_ff <= '0;
         o_so_oe   <= 1'b0;
      end else begin
         // Released pin while paused or deselected
         // Enable waits for the first falling edge so no stale bit is driven
         o_so_oe <= cs_act && hold_s2_ff && out_phase &&                 // [R2] [R16]
                    (o_so_oe || load_out || bit_ff != FIRST_BIT);
         if (load_out) begin
            if (cmd_ff == status_read_cmd) begin
               {o_so, out_sr_ff} <= status;                              // [R16] [R20]
            end else begin
               {o_so, out_sr_ff} <= fifo_out_valid ? fifo_out_data : '0; // [R24]
            end
         end else if (sck_fall && out_phase) begin
            o_so      <= out_sr_ff[6];                                   // [R16] [R17]
            out_sr_ff <= {out_sr_ff[5:0], 1'b0};
         end
      end
   end

endmodule : sep_eeprom

// ==== sim/sep_eeprom_monitor.sv ====
`timescale 1ns/1ps
module sep_eeprom_monitor #(
   parameter int P_WRITE_CYCLES = 625000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Link and control pins
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic i_wp_n,
   input wire logic i_hold_n
);
   logic       sck_ff;
   logic [3:0] age_ff;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sck_ff <= 1'b0;
      end else begin
         sck_ff <= i_sck;
      end
   end

   // Age since the raw clock pin fell; saturates so it never wraps
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         age_ff <= 4'hf;
      end else if (sck_ff && !i_sck) begin
         age_ff <= 4'h0;
      end else if (age_ff != 4'hf) begin
         age_ff <= age_ff + 4'h1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_deselected; i_cs_n [*5]; endsequence
   sequence s_paused; !i_hold_n [*6]; endsequence
   sequence s_clk_high; (i_sck && !i_cs_n) [*5]; endsequence

   AST_OE_DESELECTED: assert property (s_deselected |-> !o_so_oe)
      else $error("output enabled while deselected");
   AST_OE_PAUSED: assert property (s_paused |-> !o_so_oe)
      else $error("output enabled while paused");
   AST_SO_PAUSED: assert property (s_paused |-> $stable(o_so))
      else $error("output moved while paused");
   AST_OE_RISE_SEL: assert property ($rose(o_so_oe) |-> !i_cs_n && i_hold_n)
      else $error("output enabled outside an active frame");
   // Release after a pause re-enables without a clock fall
   AST_OE_RISE_FALL: assert property ($rose(o_so_oe) && $past(i_hold_n, 4)
      |-> age_ff < 4'h6)
      else $error("output enabled away from a clock fall");
   AST_SO_AFTER_FALL: assert property ($changed(o_so) && o_so_oe && $past(o_so_oe)
      |-> age_ff < 4'h6)
      else $error("output bit changed away from a clock fall");
   AST_SO_CLK_HIGH: assert property (s_clk_high |-> $stable(o_so))
      else $error("output bit changed while clock high");
   AST_OE_FALL_CAUSE: assert property ($fell(o_so_oe) |-> i_cs_n || !i_hold_n)
      else $error("output released without deselect or pause");
endmodule : sep_eeprom_monitor

bind sep_eeprom sep_eeprom_monitor #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) sep_eeprom_monitor_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si),
   .o_so(o_so), .o_so_oe(o_so_oe), .i_wp_n(i_wp_n), .i_hold_n(i_hold_n));

// ==== sim/sep_spi_master.sv ====
`timescale 1ns/1ps
module sep_spi_master (
   // Link pins
   output logic       o_cs_n,
   output logic       o_sck,
   output logic       o_si,
   output logic       o_hold_n,
   input  wire logic  i_so,
   // Captured bytes
   output logic [7:0] o_rx,
   output logic       o_rx_stb
);
   localparam time HALF = 40ns;

   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
      o_hold_n = 1'b1;
      o_rx = 8'h00;
      o_rx_stb = 1'b0;
   end

   // Pause moves only with clock low; the clock keeps pulsing meanwhile
   task automatic pause();
      #HALF o_hold_n = 1'b0;
      repeat (2) begin
         #HALF o_sck = 1'b1;
         #HALF o_sck = 1'b0;
      end
      #HALF o_hold_n = 1'b1;
      #HALF;
   endtask : pause

   // Mode 0, most significant bit first; read late in the high half for margin
   task automatic xfer(input logic [7:0] tx, input bit cap, input bit hp);
      for (int i = 7; i >= 0; i--) begin
         if (hp && i == 3) pause();
         o_si = tx[i];
         #HALF o_sck = 1'b1;
         o_rx_stb = 1'b0;
         #HALF o_rx[i] = i_so;
         o_sck = 1'b0;
      end
      o_rx_stb = cap;
   endtask : xfer

   task automatic start();
      o_cs_n = 1'b0;
      #HALF;
   endtask : start

   // Deselect before any further rising clock; released data line flips
   task automatic stop();
      #HALF o_cs_n = 1'b1;
      o_si = ~o_si;
      #(4 * HALF);
   endtask : stop
endmodule : sep_spi_master

// ==== sim/sep_eeprom_tb.sv ====
`timescale 1ns/1ps
module sep_eeprom_tb;
   localparam int WC = 400;
   logic       i_clk, i_rst, i_wp_n, cs_n, sck, si, hold_n, so, so_oe, rx_stb;
   logic [7:0] rx, exp_v, r0, r1;
   logic [7:0] pg [32];
   logic [7:0] exp_q [$];
   int         err_count, total_checks, cyc;

   sep_eeprom #(.P_WRITE_CYCLES(WC)) sep_eeprom_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
      .o_so(so), .o_so_oe(so_oe), .i_wp_n(i_wp_n), .i_hold_n(hold_n));
   sep_spi_master sep_spi_master_inst (
      // Released line reads as the inverse, so sampling it undriven fails
      .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n), .i_so(so_oe ? so : ~so),
      .o_rx(rx), .o_rx_stb(rx_stb));

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : check_byte

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic x(input logic [7:0] b, input bit c = 0, input bit h = 0);
      sep_spi_master_inst.xfer(b, c, h);
   endtask : x

   task automatic go(input logic [7:0] op);
      @(posedge i_clk);
      #1;
      sep_spi_master_inst.start();
      x(op);
   endtask : go

   task automatic cmd(input logic [7:0] op);
      go(op);
      sep_spi_master_inst.stop();
   endtask : cmd

   task automatic rd_status(input logic [7:0] e);
      exp_q.push_back(e);
      exp_q.push_back(e);
      go(8'h05);
      x(8'h00, 1);
      x(8'h00, 1);
      sep_spi_master_inst.stop();
   endtask : rd_status

   task automatic wr_status(input logic [7:0] v);
      go(8'h01);
      x(v);
      sep_spi_master_inst.stop();
   endtask : wr_status

   task automatic addr(input logic [7:0] op, input logic [15:0] a);
      go(op);
      x(a[15:8]);
      x(a[7:0]);
   endtask : addr

   task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
      cmd(8'h06);
      addr(8'h02, a);
      x(d);
      sep_spi_master_inst.stop();
   endtask : wr_byte

   task automatic wait_wr();
      repeat (WC + 50) @(posedge i_clk);
   endtask : wait_wr

   task automatic set_wp(input logic v, input string t);
      $display("test %s done", t);
      @(posedge i_clk);
      #1 i_wp_n = v;
   endtask : set_wp

   // Oldest expectation pairs with each captured byte
   always @(posedge rx_stb) begin
      exp_v = exp_q.pop_front();
      check_byte("so byte", exp_v, rx);
   end

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      i_rst = 1'b1;
      i_wp_n = 1'b1;
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      r0 = 8'($urandom(32'hb681));
      r1 = 8'($urandom);
      repeat (20) @(posedge i_clk);
      #1 i_rst = 1'b0;
      repeat (5) @(posedge i_clk);
      rd_status(8'h00);
      wr_status(8'h8c);
      rd_status(8'h00);
      cmd(8'h16);
      rd_status(8'h00);
      cmd(8'h0e);
      rd_status(8'h02);
      cmd(8'h04);
      rd_status(8'h00);
      wr_byte(16'h1fff, r0);
      rd_status(8'hff);
      wait_wr();
      wr_byte(16'h0000, r1);
      wait_wr();
      cmd(8'h06);
      wr_status(8'hfc);
      wr_status(8'h00);
      wait_wr();
      rd_status(8'h8c);
      wr_byte(16'h0000, ~r1);
      wait_wr();
      set_wp(1'b0, "latch and array");
      cmd(8'h06);
      wr_status(8'h84);
      rd_status(8'h8e);
      set_wp(1'b1, "refused status");
      wr_status(8'h84);
      wait_wr();
      rd_status(8'h84);
      set_wp(1'b0, "status update");
      wr_byte(16'h1fff, ~r0);
      wait_wr();
      exp_q.push_back(r0);
      exp_q.push_back(r1);
      addr(8'h03, 16'h1fff);
      x(8'h00, 1);
      x(8'h00, 1);
      sep_spi_master_inst.stop();
      cmd(8'h06);
      addr(8'h02, 16'h17fe);
      for (int k = 0; k < 34; k++) begin
         pg[(30 + k) % 32] = 8'($urandom);
         x(pg[(30 + k) % 32]);
      end
      sep_spi_master_inst.stop();
      wait_wr();
      for (int k = 0; k < 32; k++) exp_q.push_back(pg[k]);
      addr(8'h03, 16'hf7e0);
      for (int k = 0; k < 32; k++) x(8'h00, 1, k == 5);
      sep_spi_master_inst.stop();
      $display("test guard and page done");
      close_out();
   end
endmodule : sep_eeprom_tb
